// *** logic/pgp_pkg.sv ***
// Constants for the port 1 general-purpose I/O block
package pgp_pkg;
   localparam int PORT_WIDTH = 7;
   localparam int REG_WIDTH = 8;
   localparam logic [11:0] OFF_OUTPUT_DATA = 12'h000;
   localparam logic [11:0] OFF_DIRECTION = 12'h004;
   localparam logic [11:0] OFF_PULLUP = 12'h008;
   localparam logic [11:0] OFF_FUNC_SELECT = 12'h00C;
   localparam int ADDR_BITS = 12;
   localparam int RESERVED_BIT = 7;
   localparam int FUNC_LOW_EVENT_BIT = 1;
   localparam int FUNC_HIGH_EVENT_BIT = 0;
   localparam int FUNC_USED_BITS = 2;
   localparam logic [6:0] PORT_RESET = 7'h00;
   localparam logic [1:0] FUNC_RESET = 2'h0;
   localparam logic [6:0] DIR_READ_VALUE = 7'h7F;
   localparam logic [5:0] FUNC_RESERVED_READ = 6'h3F;
   localparam logic RESERVED_READ = 1'b1;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [1:0] HRESP_OKAY = 2'h0;
endpackage : pgp_pkg

// *** logic/pgp_port1.sv ***
// Port 1 general-purpose I/O with pin function select, AHB-Lite slave
// Behaviour
// - After reset every pin is an input.
// - Output data is held in a data register and each pin's direction is set individually.
// - Register settings choose between general port use and peripheral function for pins zero and one; the other pins are always general.
// - Reading output data for an output pin returns the stored value.
// - Reading output data for an input pin returns the synchronised pin level.
// - Bit 7 of output data, direction and pull-up reads as 1 and ignores writes.
// - A direction bit of 1 makes its pin an output, 0 an input.
// - Direction and output data drive a pin only while it has the general port function; direction also gates the pull-up in both functions.
// - The direction register is write-only and reads as all ones.
// - On an input pin the pull-up bit switches the pull-up on or off.
// - Function select bit 1 routes pin one to the low event-counter input.
// - Function select bit 0 routes pin zero to the high event-counter input.
// - Function select bits 7 to 2 read as 1 and ignore writes.
//
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pgp_port1 #(
   parameter int WIDTH = pgp_pkg::PORT_WIDTH
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic [1:0] hresp,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] pin_out,
   output logic [WIDTH-1:0] pin_oe,
   output logic [WIDTH-1:0] pin_pullup_en,
   output logic event_count_low_input,
   output logic event_count_high_input
);
   logic [WIDTH-1:0] port_output_data;
   logic [WIDTH-1:0] port_direction;
   logic [WIDTH-1:0] port_pullup_enable;
   logic [pgp_pkg::FUNC_USED_BITS-1:0] port_pin_function_select;
   logic [WIDTH-1:0] pin_meta;
   logic [WIDTH-1:0] pin_sync;
   logic wr_pend;
   logic [pgp_pkg::ADDR_BITS-1:0] wr_addr;
   logic [31:0] rdata;

   // Address phase decode; only single (NONSEQ) transfers matter, hsize is not checked
   wire addr_valid = hsel && hready && (htrans == pgp_pkg::HTRANS_NONSEQ);
   wire wr_start = addr_valid && hwrite;
   wire rd_start = addr_valid && !hwrite;
   wire [pgp_pkg::ADDR_BITS-1:0] a_addr = haddr[pgp_pkg::ADDR_BITS-1:0];
   wire wr_data_sel = wr_pend && (wr_addr == pgp_pkg::OFF_OUTPUT_DATA);
   wire wr_dir_sel = wr_pend && (wr_addr == pgp_pkg::OFF_DIRECTION);
   wire wr_pull_sel = wr_pend && (wr_addr == pgp_pkg::OFF_PULLUP);
   wire wr_func_sel = wr_pend && (wr_addr == pgp_pkg::OFF_FUNC_SELECT);

   // Per-pin general port enable: pins without a peripheral are always general
   logic [WIDTH-1:0] general_fn;
   always_comb begin
      general_fn = '1;
      general_fn[0] = !port_pin_function_select[pgp_pkg::FUNC_HIGH_EVENT_BIT];
      general_fn[1] = !port_pin_function_select[pgp_pkg::FUNC_LOW_EVENT_BIT];
   end

   // Mixed read: output pins show the register, input pins show the pin
   wire [WIDTH-1:0] data_readback = (port_direction & port_output_data) | (~port_direction & pin_sync);

   // Read mux; bit 7 forced high on the byte registers
   wire [31:0] rd_mux =
      (a_addr == pgp_pkg::OFF_OUTPUT_DATA) ? {24'h000000, pgp_pkg::RESERVED_READ, data_readback} :
      (a_addr == pgp_pkg::OFF_DIRECTION) ? {24'h000000, pgp_pkg::RESERVED_READ, pgp_pkg::DIR_READ_VALUE} :
      (a_addr == pgp_pkg::OFF_PULLUP) ? {24'h000000, pgp_pkg::RESERVED_READ, port_pullup_enable} :
      (a_addr == pgp_pkg::OFF_FUNC_SELECT) ? {24'h000000, pgp_pkg::FUNC_RESERVED_READ, port_pin_function_select} :
      32'h00000000;

   // Pin synchroniser; first stage feeds only the second
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pin_meta <= '0;
         pin_sync <= '0;
      end else begin
         pin_meta <= pin_in;
         pin_sync <= pin_meta;
      end
   end

   // Bus phase tracking
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend <= 1'b0;
         wr_addr <= '0;
         rdata <= 32'h00000000;
      end else begin
         if (hready) begin
            wr_pend <= wr_start;
         end
         if (wr_start) begin
            wr_addr <= a_addr;
         end
         if (rd_start) begin
            rdata <= rd_mux;
         end
      end
   end

   // Register writes; reserved bits have no storage
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         port_output_data <= pgp_pkg::PORT_RESET;
         port_direction <= pgp_pkg::PORT_RESET;
         port_pullup_enable <= pgp_pkg::PORT_RESET;
         port_pin_function_select <= pgp_pkg::FUNC_RESET;
      end else begin
         if (wr_data_sel) begin
            port_output_data <= hwdata[WIDTH-1:0];
         end
         if (wr_dir_sel) begin
            port_direction <= hwdata[WIDTH-1:0];
         end
         if (wr_pull_sel) begin
            port_pullup_enable <= hwdata[WIDTH-1:0];
         end
         if (wr_func_sel) begin
            port_pin_function_select <= hwdata[pgp_pkg::FUNC_USED_BITS-1:0];
         end
      end
   end

   // Pin drive per bit
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_pin
         assign pin_oe[gi] = general_fn[gi] && port_direction[gi];
         assign pin_out[gi] = general_fn[gi] && port_output_data[gi];
         // Peripheral inputs still want a pull-up, so it follows direction only
         assign pin_pullup_en[gi] = !port_direction[gi] && port_pullup_enable[gi];
      end
   endgenerate

   // Event counter inputs see the pin only when routed there
   assign event_count_low_input = port_pin_function_select[pgp_pkg::FUNC_LOW_EVENT_BIT] && pin_sync[1];
   assign event_count_high_input = port_pin_function_select[pgp_pkg::FUNC_HIGH_EVENT_BIT] && pin_sync[0];

   assign hrdata = rdata;
   assign hreadyout = 1'b1;
   assign hresp = pgp_pkg::HRESP_OKAY;
endmodule : pgp_port1
`default_nettype wire

// *** dv/pgp_board_model.sv ***
// Board side of the seven port pins
`timescale 1ns/1ps
`default_nettype none
module pgp_board_model (
   input wire logic [6:0] pin_out, pin_oe, pin_pullup_en, ext, flt,
   output logic [6:0] pin_in
);
   // A driven pin shows the block's level; an open (flt) line sits at the pull-up, else at the inverse of ext; other lines follow ext
   assign pin_in = pin_oe & pin_out | ~pin_oe & (flt & (pin_pullup_en | ~ext) | ~flt & ext);
endmodule : pgp_board_model
`default_nettype wire

// *** dv/pgp_port1_props.sv ***
// Assertions on the port 1 block
`timescale 1ns/1ps
`default_nettype none
module pgp_port1_props #(parameter int WIDTH = 7) (
   input wire logic hclk, hresetn, hsel, hwrite, hready, event_count_low_input, event_count_high_input,
   input wire logic [1:0] htrans,
   input wire logic [31:0] haddr, hrdata,
   input wire logic [WIDTH-1:0] pin_out, pin_oe, pin_pullup_en
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire rd = hsel && hready && htrans == 2'h2 && !hwrite;
   wire [11:0] a = haddr[11:0];
   pull_excl_a: assert property (!(|(pin_oe & pin_pullup_en))) else $error("pull-up on output");
   reset_in_a: assert property ($rose(hresetn) |-> !(|pin_oe)) else $error("output after reset");
   dir_read_a: assert property (rd && a == 12'h4 |=> hrdata[7:0] == 8'hFF) else $error("direction read");
   sel_rsv_a: assert property (rd && a == 12'hC |=> hrdata[7:2] == 6'h3F) else $error("select read");
   bit7_rsv_a: assert property (rd && (a == 12'h0 || a == 12'h8) |=> hrdata[7]) else $error("bit 7 read");
   out_read_a: assert property (rd && a == 12'h0 && &pin_oe |=> hrdata[WIDTH-1:0] == $past(pin_out))
      else $error("output read");
   ev_low_a: assert property (event_count_low_input |-> !pin_oe[1]) else $error("pin one driven");
   ev_high_a: assert property (event_count_high_input |-> !pin_oe[0]) else $error("pin zero driven");
   cover property (rd && a == 12'h0 && &pin_oe);
   cover property (|pin_pullup_en);
   cover property (event_count_low_input);
endmodule : pgp_port1_props
bind pgp_port1 pgp_port1_props #(.WIDTH(WIDTH)) pgp_port1_props_inst (.*);
`default_nettype wire

// *** dv/port1_gpio_with_pin_select_tb.sv ***
// Bench for the port 1 block
`timescale 1ns/1ps
`default_nettype none
module port1_gpio_with_pin_select_tb;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, event_count_low_input, event_count_high_input;
   logic [1:0] htrans = 0, hresp;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
   logic [6:0] pin_in, pin_out, pin_oe, pin_pullup_en, ext = 7'h55, flt = 0;
   wire hready = hreadyout;
   int n_errors = 0, compares = 0;
   initial forever #10 hclk = ~hclk;
   pgp_port1 pgp_port1_inst (.*, .hsize(3'h2));
   pgp_board_model pgp_board_model_inst (.*);
   task automatic close_out;
      $display("%0d compares, %0d errors", compares, n_errors);
      if (n_errors == 0 && compares > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : close_out
   task automatic chk(string n, logic [31:0] s, e);
      compares++;
      if (s !== e) begin n_errors++; $display("Error %s expected %h seen %h", n, e, s); end
   endtask : chk
   // Bounded wait; a missing answer ends the run
   task automatic wt;
      for (int i = 0; i < 50; i++) begin @(posedge hclk); if (hready === 1'b1) return; end
      n_errors++; close_out;
   endtask : wt
   // One idle after each transfer keeps read-after-write safe
   task automatic xf(logic w, logic [11:0] a, logic [31:0] d);
      hsel <= '1; htrans <= 2'h2; hwrite <= w; haddr <= {20'h0, a}; wt;
      hsel <= '0; htrans <= 2'h0; hwdata <= d; wt; q = hrdata; @(posedge hclk);
   endtask : xf
   task automatic rc(logic [11:0] a, logic [31:0] e);
      xf(0, a, 0); chk("hrdata", q, e);
   endtask : rc
   initial begin
      repeat (12) @(posedge hclk);
      hresetn <= '1; repeat (3) @(posedge hclk);
      rc(12'h0, 32'hD5); rc(12'h4, 32'hFF); rc(12'h8, 32'h80); rc(12'hC, 32'hFC); rc(12'h10, 0);
      $display("Reset test done");
      xf(1, 12'h0, 32'h2A); xf(1, 12'h4, 32'hFF); ext <= '0; flt <= 7'h7F; repeat (3) @(posedge hclk);
      chk("pin_oe", pin_oe, 32'h7F); rc(12'h0, 32'hAA);
      chk("pin_out", pin_out, 32'h2A);
      $display("Output test done");
      ext <= 7'h7F; xf(1, 12'h4, 32'h0F); xf(1, 12'h8, 32'hFF); repeat (3) @(posedge hclk);
      rc(12'h0, 32'hFA); chk("pullup", pin_pullup_en, 32'h70);
      xf(1, 12'h8, 0); ext <= 7'h7F; repeat (3) @(posedge hclk); rc(12'h0, 32'h8A);
      $display("Pull-up test done");
      ext <= 7'h03; flt <= '0; xf(1, 12'hC, 32'hFF); rc(12'hC, 32'hFF); chk("pin_oe", pin_oe, 32'h0C);
      chk("pin_out", pin_out, 32'h28); xf(1, 12'h8, 32'hFF); chk("pullup", pin_pullup_en, 32'h70);
      rc(12'h8, 32'hFF);
      chk("low", event_count_low_input, 1); chk("high", event_count_high_input, 1);
      xf(1, 12'hC, 32'h01); chk("pin_oe", pin_oe, 32'h0E); chk("low", event_count_low_input, 0);
      chk("high", event_count_high_input, 1);
      $display("Function test done");
      hresetn <= '0; @(posedge hclk); hresetn <= '1; @(posedge hclk);
      rc(12'hC, 32'hFC); chk("pin_oe", pin_oe, 0); chk("pullup", pin_pullup_en, 0);
      $display("Second reset test done");
      close_out;
   end
endmodule : port1_gpio_with_pin_select_tb
`default_nettype wire
